// file: verilog/video_pdu_rx.sv
// Package and receive-side parser for motion-video parameters and units
//
// Behaviour
// - Region list: type 4, length sixteen per rectangle
// - Rectangle is four signed words, low before high
// - Key record type 5, length gives key size
// - Frame period type 6, length 4, one word
// - Colour record type 3, length 4, four bytes
// - Format bit 0 flags synchronous clocks
// - Format bits 2:1 component format, 11 reserved
// - Format bit 3 selects full or consumer range
// - Format bit 4 selects the YCbCr standard
// - Format bits 7:5 bits per component
// - Stereo byte bit 0 flags even line count
// - Stereo bits 2:1 eye order, 10 never used
// - Stream closed once close response passes
// - Unit header 00, channel, 28, 01, total length
// - Two reserved control bits carry nothing
// - Device advertises its video command support
// - Parameters change live, no channel reopen
// - Unknown parameter answered as invalid parameter
`default_nettype none

package video_pdu_pkg;
  localparam int          WORD_W      = 32;
  localparam int          FIFO_W      = 34;
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [15:0] TYPE_PLACE  = 16'h0001;
  localparam logic [15:0] TYPE_SRCCNT = 16'h0002;
  localparam logic [15:0] TYPE_COLOR  = 16'h0003;
  localparam logic [15:0] TYPE_REGION = 16'h0004;
  localparam logic [15:0] TYPE_KEY    = 16'h0005;
  localparam logic [15:0] TYPE_PERIOD = 16'h0006;
  localparam logic [15:0] LEN_ONE     = 16'h0004;
  localparam logic [15:0] LEN_TWO     = 16'h0008;
  localparam logic [15:0] RECT_MASK   = 16'h000F;
  localparam logic [7:0]  UNIT_LEAD   = 8'h00;
  localparam logic [7:0]  UNIT_CLASS  = 8'h28;
  localparam logic [7:0]  UNIT_VIDEO  = 8'h01;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam int          LAST_BIT    = 31;
  localparam int          FIRST_BIT   = 30;
  localparam int          VIEW_MSB    = 27;
  localparam int          VIEW_LSB    = 16;
  localparam logic [1:0]  FMT_RSV     = 2'h3;
  localparam logic [1:0]  STEREO_RSV  = 2'h2;
  localparam logic [4:0]  STEREO_PAD  = 5'h00;
  localparam logic [11:0] VIEW_WHOLE  = 12'h000;
  localparam logic [15:0] CODEC_NONE  = 16'h0000;
  localparam logic [13:0] CNT_RESET   = 14'h0000;

  typedef enum logic [2:0] {
    S_HEAD  = 3'h0,
    S_CLASS = 3'h1,
    S_STAMP = 3'h3,
    S_SEQ   = 3'h2,
    S_CTL   = 3'h6,
    S_DATA  = 3'h7,
    S_BODY  = 3'h5,
    S_SKIP  = 3'h4
  } state_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module video_pdu_rx #(
  parameter logic VIDEO_CMD_SUPPORT = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Channel control
  input  wire logic [23:0] chan_id_i,
  input  wire logic        open_i,
  input  wire logic        close_resp_i,
  output logic             stream_closed_o,
  output logic             video_support_o,
  // Incoming words, cmd_i high for video unit words
  input  wire logic [31:0] in_data_i,
  input  wire logic        in_cmd_i,
  input  wire logic        in_last_i,
  input  wire logic        in_valid_i,
  output logic             in_ready_o,
  // Region list
  output logic [31:0]      rect_x_lo_o,
  output logic [31:0]      rect_y_lo_o,
  output logic [31:0]      rect_x_hi_o,
  output logic [31:0]      rect_y_hi_o,
  output logic             rect_valid_o,
  // Key and frame period
  output logic [31:0]      color_key_o,
  output logic [15:0]      color_key_len_o,
  output logic [31:0]      frame_period_o,
  // Colorimetry
  output logic [7:0]       pixel_format_byte_o,
  output logic [7:0]       stereo_interlace_byte_o,
  output logic             sync_clk_o,
  output logic [1:0]       comp_fmt_o,
  output logic             cea_range_o,
  output logic             bt709_o,
  output logic [4:0]       bits_per_comp_o,
  output logic             lines_even_o,
  output logic [1:0]       stereo_o,
  output logic             color_valid_o,
  // Video unit header
  output logic [31:0]      channel_timestamp_o,
  output logic [15:0]      tx_seq_o,
  output logic [15:0]      rx_seq_o,
  output logic             frame_last_flag_o,
  output logic             frame_first_flag_o,
  output logic [11:0]      target_view_index_o,
  output logic             whole_display_o,
  output logic [15:0]      codec_index_o,
  output logic             codec_none_o,
  output logic             hdr_valid_o,
  output logic             present_hint_o,
  // Video payload
  output logic [31:0]      vid_data_o,
  output logic             vid_end_o,
  output logic             vid_valid_o,
  input  wire logic        vid_ready_i,
  // Errors, one-cycle pulses; invalid_type_o holds the last unknown type
  output logic             frame_err_o,
  output logic             enc_err_o,
  output logic             seq_err_o,
  output logic             invalid_param_o,
  output logic [15:0]      invalid_type_o
);

  function automatic logic [15:0] bytes_of(input logic [13:0] words);
    bytes_of = {words, 2'b00};
  endfunction

  // Unknown widths decode to zero
  function automatic logic [4:0] bpc_of(input logic [2:0] code);
    case (code)
      3'h0:    bpc_of = 5'h06;
      3'h1:    bpc_of = 5'h08;
      3'h2:    bpc_of = 5'h0A;
      3'h3:    bpc_of = 5'h0C;
      3'h4:    bpc_of = 5'h10;
      default: bpc_of = 5'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  logic [33:0]                f_data;
  logic                       f_valid;
  logic                       fifo_ready;
  video_pdu_pkg::state_t      state_reg;
  video_pdu_pkg::state_t      state_next;
  logic [13:0]                cnt_reg;
  logic [15:0]                ptype_reg;
  logic [15:0]                plen_reg;
  logic [15:0]                vlen_reg;
  logic                       prev_last_reg;
  logic [31:0]                rect_reg [4];
  localparam int              VMSB = video_pdu_pkg::VIEW_MSB;
  localparam int              VLSB = video_pdu_pkg::VIEW_LSB;

  // Payload consumer stall backs up into the FIFO and the source
  wire        stall    = vid_valid_o && !vid_ready_i;
  wire        pop_ok   = !stall;

  video_pdu_fifo #(
    .W (video_pdu_pkg::FIFO_W),
    .D (video_pdu_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_data_i  ({in_cmd_i, in_last_i, in_data_i}),
    .wr_valid_i (in_valid_i && in_ready_o),
    .wr_ready_o (fifo_ready),
    .rd_data_o  (f_data),
    .rd_valid_o (f_valid),
    .rd_ready_i (pop_ok)
  );

  wire        pop      = f_valid && pop_ok;
  wire [31:0] w        = f_data[31:0];
  wire        w_last   = f_data[32];
  wire        w_cmd    = f_data[33];
  wire [15:0] w_hi     = w[31:16];
  wire [15:0] w_lo     = w[15:0];
  wire [13:0] body_idx = cnt_reg - 14'h0001;
  wire        live     = !stream_closed_o && !close_resp_i;

  // Header decode; type 3 with two words is a pixel count record
  wire is_region = w_hi == video_pdu_pkg::TYPE_REGION;
  wire is_key    = w_hi == video_pdu_pkg::TYPE_KEY;
  wire is_period = w_hi == video_pdu_pkg::TYPE_PERIOD
                && w_lo == video_pdu_pkg::LEN_ONE;
  wire is_color  = w_hi == video_pdu_pkg::TYPE_COLOR
                && w_lo == video_pdu_pkg::LEN_ONE;
  wire is_other  = w_hi == video_pdu_pkg::TYPE_PLACE
                || w_hi == video_pdu_pkg::TYPE_SRCCNT
                || (w_hi == video_pdu_pkg::TYPE_COLOR
                    && w_lo == video_pdu_pkg::LEN_TWO);
  wire known     = is_region || is_key || is_period || is_color || is_other;
  wire region_ok = (w_lo & video_pdu_pkg::RECT_MASK) == 16'h0000;

  // Unit header checks, bytes taken most significant first
  wire lead_ok   = w[31:24] == video_pdu_pkg::UNIT_LEAD
                && w[23:0] == chan_id_i;
  wire class_ok  = w[31:24] == video_pdu_pkg::UNIT_CLASS
                && w[23:16] == video_pdu_pkg::UNIT_VIDEO;

  // Colour byte decode
  wire [7:0] fmt_b    = w[31:24];
  wire [7:0] ster_b   = w[23:16];
  wire       color_bad = fmt_b[2:1] == video_pdu_pkg::FMT_RSV
                      || bpc_of(fmt_b[7:5]) == 5'h00
                      || ster_b[2:1] == video_pdu_pkg::STEREO_RSV
                      || ster_b[7:3] != video_pdu_pkg::STEREO_PAD
                      || w[15:8] != video_pdu_pkg::ZERO_BYTE
                      || w[7:0] != video_pdu_pkg::ZERO_BYTE;

  // Length closes the record on the word marked last
  wire plen_ok = plen_reg == bytes_of(cnt_reg);
  wire vlen_ok = vlen_reg == bytes_of(cnt_reg + 14'h0001);
  wire in_body = state_reg == video_pdu_pkg::S_BODY;
  wire in_data = state_reg == video_pdu_pkg::S_DATA;
  wire vid_en  = w_cmd && VIDEO_CMD_SUPPORT;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      video_pdu_pkg::S_HEAD: begin
        if (!vid_en && w_cmd)
          state_next = video_pdu_pkg::S_SKIP;
        else if (w_cmd)
          state_next = lead_ok ? video_pdu_pkg::S_CLASS
                               : video_pdu_pkg::S_SKIP;
        else
          state_next = (known && (!is_region || region_ok))
                       ? video_pdu_pkg::S_BODY : video_pdu_pkg::S_SKIP;
      end
      video_pdu_pkg::S_CLASS:
        state_next = class_ok ? video_pdu_pkg::S_STAMP
                              : video_pdu_pkg::S_SKIP;
      video_pdu_pkg::S_STAMP: state_next = video_pdu_pkg::S_SEQ;
      video_pdu_pkg::S_SEQ:   state_next = video_pdu_pkg::S_CTL;
      video_pdu_pkg::S_CTL:   state_next = video_pdu_pkg::S_DATA;
      video_pdu_pkg::S_DATA:  state_next = video_pdu_pkg::S_DATA;
      video_pdu_pkg::S_BODY:  state_next = video_pdu_pkg::S_BODY;
      video_pdu_pkg::S_SKIP:  state_next = video_pdu_pkg::S_SKIP;
      default:                state_next = video_pdu_pkg::S_HEAD;
    endcase
    if (!live)
      state_next = video_pdu_pkg::S_SKIP;
    if (w_last)
      state_next = video_pdu_pkg::S_HEAD;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= video_pdu_pkg::S_HEAD;
      cnt_reg   <= video_pdu_pkg::CNT_RESET;
    end else if (pop) begin
      state_reg <= state_next;
      cnt_reg   <= w_last ? video_pdu_pkg::CNT_RESET
                          : cnt_reg + 14'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stream_closed_o <= 1'b0;
      video_support_o <= 1'b0;
      in_ready_o      <= 1'b0;
    end else begin
      // Close wins over a reopen in the same cycle
      stream_closed_o <= close_resp_i || (stream_closed_o && !open_i);
      video_support_o <= VIDEO_CMD_SUPPORT;
      // Half rate input: a registered ready never promises a full slot
      in_ready_o      <= fifo_ready && !(in_valid_i && in_ready_o);
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Rectangle words land by position within each group of four
  generate
    for (genvar i = 0; i < 4; i++) begin : g_rect
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
          rect_reg[i] <= 32'h0000_0000;
        else if (pop && in_body && ptype_reg == video_pdu_pkg::TYPE_REGION
                 && body_idx[1:0] == 2'(i))
          rect_reg[i] <= w;
      end
    end
  endgenerate

  wire rect_done = pop && in_body && body_idx[1:0] == 2'h3
                && ptype_reg == video_pdu_pkg::TYPE_REGION;
  wire body0     = pop && in_body && cnt_reg == 14'h0001;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptype_reg <= 16'h0000;
      plen_reg  <= 16'h0000;
      vlen_reg  <= 16'h0000;
    end else if (pop) begin
      if (state_reg == video_pdu_pkg::S_HEAD) begin
        ptype_reg <= w_hi;
        plen_reg  <= w_lo;
      end
      if (state_reg == video_pdu_pkg::S_CLASS)
        vlen_reg <= w_lo;
    end
  end

  // Parameters apply on arrival, so a change record retunes a live stream
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rect_x_lo_o     <= 32'h0000_0000;
      rect_y_lo_o     <= 32'h0000_0000;
      rect_x_hi_o     <= 32'h0000_0000;
      rect_y_hi_o     <= 32'h0000_0000;
      rect_valid_o    <= 1'b0;
      color_key_o     <= 32'h0000_0000;
      color_key_len_o <= 16'h0000;
      frame_period_o  <= 32'h0000_0000;
    end else begin
      rect_valid_o <= rect_done;
      if (rect_done) begin
        rect_x_lo_o <= rect_reg[0];
        rect_y_lo_o <= rect_reg[1];
        rect_x_hi_o <= rect_reg[2];
        rect_y_hi_o <= w;
      end
      // Only the first key word is kept; wider keys are truncated
      if (body0 && ptype_reg == video_pdu_pkg::TYPE_KEY) begin
        color_key_o     <= w;
        color_key_len_o <= plen_reg;
      end
      if (body0 && ptype_reg == video_pdu_pkg::TYPE_PERIOD
          && plen_reg == video_pdu_pkg::LEN_ONE)
        frame_period_o <= w;
    end
  end

  wire color_hit = body0 && ptype_reg == video_pdu_pkg::TYPE_COLOR
                && plen_reg == video_pdu_pkg::LEN_ONE;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pixel_format_byte_o     <= 8'h00;
      stereo_interlace_byte_o <= 8'h00;
      sync_clk_o              <= 1'b0;
      comp_fmt_o              <= 2'h0;
      cea_range_o             <= 1'b0;
      bt709_o                 <= 1'b0;
      bits_per_comp_o         <= 5'h00;
      lines_even_o            <= 1'b0;
      stereo_o                <= 2'h0;
      color_valid_o           <= 1'b0;
    end else begin
      color_valid_o <= color_hit;
      if (color_hit) begin
        pixel_format_byte_o     <= fmt_b;
        stereo_interlace_byte_o <= ster_b;
        sync_clk_o              <= fmt_b[0];
        comp_fmt_o              <= fmt_b[2:1];
        cea_range_o             <= fmt_b[3];
        bt709_o                 <= fmt_b[4];
        bits_per_comp_o         <= bpc_of(fmt_b[7:5]);
        lines_even_o            <= ster_b[0];
        stereo_o                <= ster_b[2:1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  wire ctl_hit = pop && state_reg == video_pdu_pkg::S_CTL && live;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      channel_timestamp_o <= 32'h0000_0000;
      tx_seq_o            <= 16'h0000;
      rx_seq_o            <= 16'h0000;
      frame_last_flag_o   <= 1'b0;
      frame_first_flag_o  <= 1'b0;
      target_view_index_o <= 12'h000;
      whole_display_o     <= 1'b0;
      codec_index_o       <= 16'h0000;
      codec_none_o        <= 1'b0;
      hdr_valid_o         <= 1'b0;
      prev_last_reg       <= 1'b0;
    end else begin
      hdr_valid_o <= ctl_hit;
      if (pop && state_reg == video_pdu_pkg::S_STAMP)
        channel_timestamp_o <= w;
      if (pop && state_reg == video_pdu_pkg::S_SEQ) begin
        tx_seq_o <= w_hi;
        rx_seq_o <= w_lo;
      end
      // Bits 29:28 are dropped on purpose
      if (ctl_hit) begin
        frame_last_flag_o   <= w[video_pdu_pkg::LAST_BIT];
        frame_first_flag_o  <= w[video_pdu_pkg::FIRST_BIT];
        target_view_index_o <= w[VMSB:VLSB];
        whole_display_o     <= w[VMSB:VLSB] == video_pdu_pkg::VIEW_WHOLE;
        codec_index_o       <= w_lo;
        codec_none_o        <= w_lo == video_pdu_pkg::CODEC_NONE;
        prev_last_reg       <= w[video_pdu_pkg::LAST_BIT];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vid_data_o     <= 32'h0000_0000;
      vid_end_o      <= 1'b0;
      vid_valid_o    <= 1'b0;
      present_hint_o <= 1'b0;
    end else begin
      present_hint_o <= pop && in_data && w_last && frame_last_flag_o;
      if (pop && in_data && live) begin
        vid_data_o  <= w;
        vid_end_o   <= w_last;
        vid_valid_o <= 1'b1;
      end else if (vid_ready_i) begin
        vid_valid_o <= 1'b0;
      end
    end
  end

  // Unit ending after its lead word but before its data, or with a wrong length, counts as a framing error
  wire early_end = pop && w_last && (state_reg == video_pdu_pkg::S_CLASS
                || state_reg == video_pdu_pkg::S_STAMP
                || state_reg == video_pdu_pkg::S_SEQ
                || state_reg == video_pdu_pkg::S_CTL);
  wire bad_head  = pop && state_reg == video_pdu_pkg::S_HEAD && live
                && ((w_cmd && vid_en && !lead_ok)
                    || (!w_cmd && is_region && !region_ok));
  wire bad_len   = pop && w_last && ((in_body && !plen_ok)
                || (in_data && !vlen_ok)
                || (state_reg == video_pdu_pkg::S_HEAD && !w_cmd
                    && known && w_lo != 16'h0000));
  wire bad_class = pop && state_reg == video_pdu_pkg::S_CLASS && !class_ok;
  wire unknown   = pop && state_reg == video_pdu_pkg::S_HEAD && live
                && !w_cmd && !known;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_err_o     <= 1'b0;
      enc_err_o       <= 1'b0;
      seq_err_o       <= 1'b0;
      invalid_param_o <= 1'b0;
      invalid_type_o  <= 16'h0000;
    end else begin
      frame_err_o     <= early_end || bad_head || bad_len || bad_class;
      enc_err_o       <= color_hit && color_bad;
      seq_err_o       <= ctl_hit && prev_last_reg
                      && !w[video_pdu_pkg::FIRST_BIT];
      invalid_param_o <= unknown;
      if (unknown)
        invalid_type_o <= w_hi;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  closed_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    close_resp_i |=> stream_closed_o [*2])
    else $error("stream not held closed after close response");
  view_whole_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hdr_valid_o |-> whole_display_o == (target_view_index_o == 12'h000))
    else $error("whole display flag disagrees with view index");
  codec_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hdr_valid_o |-> codec_none_o == (codec_index_o == 16'h0000))
    else $error("unencoded flag disagrees with codec index");
  sync_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    color_valid_o |-> sync_clk_o == pixel_format_byte_o[0])
    else $error("sync clock flag wrong");
  range_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    color_valid_o |-> cea_range_o == pixel_format_byte_o[3])
    else $error("range flag wrong");
  bpc_eight_a: assert property (@(posedge clk_i) disable iff (rst_i)
    color_valid_o && pixel_format_byte_o[7:5] == 3'h1
      |-> bits_per_comp_o == 5'h08)
    else $error("bits per component wrong");
  fmt_rsv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    color_valid_o && pixel_format_byte_o[2:1] == 2'h3 |-> enc_err_o)
    else $error("reserved component format not flagged");
  stereo_rsv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    color_valid_o && stereo_interlace_byte_o[2:1] == 2'h2 |-> enc_err_o)
    else $error("reserved stereo code not flagged");
  vid_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vid_valid_o && !vid_ready_i |=> vid_valid_o && $stable(vid_data_o))
    else $error("payload dropped while stalled");

endmodule

`default_nettype wire

// file: verilog/video_pdu_fifo.sv
// Word FIFO with a registered read stage
`default_nettype none

module video_pdu_fifo #(
  parameter int W = 34,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic [W-1:0] wr_data_i,
  input  wire logic         wr_valid_i,
  output logic              wr_ready_o,
  // Drain side
  output logic [W-1:0]      rd_data_o,
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;

  assign wr_ready_o = count_reg != (AW+1)'(D);
  wire push = wr_valid_i && wr_ready_o;
  // Output stage refills whenever it is empty or being taken
  wire load = count_reg != '0 && (!rd_valid_o || rd_ready_i);

  always_ff @(posedge clk_i) begin
    if (push)
      mem[wr_ptr_reg] <= wr_data_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
        rd_data_o  <= mem[rd_ptr_reg];
        rd_valid_o <= 1'b1;
      end else if (rd_ready_i) begin
        rd_valid_o <= 1'b0;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end

endmodule

`default_nettype wire

// file: verif/payload_sink.sv
// Payload sink that stalls the video output at random
`default_nettype none

module payload_sink (
  // Clock and stall request
  input  wire logic clk_i,
  input  wire logic hold_i,
  // Payload handshake
  output logic      vid_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 22;
  initial vid_ready_o = 1'b0;
  // No kinder than a busy display: one beat in four refused
  always @(posedge clk_i) begin
    vid_ready_o <= !hold_i && ($random(seed) % 4 != 0);
  end
endmodule

`default_nettype wire

// file: verif/video_pdu_rx_test.sv
// Self-checking bench for the video parameter and unit parser
`default_nettype none

module video_pdu_rx_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, open_i = 1'b0, close_resp_i = 1'b0;
  logic in_cmd_i = 1'b0, in_last_i = 1'b0, in_valid_i = 1'b0, hold = 1'b0;
  logic [31:0] in_data_i = 32'h0, rect_x_lo_o, rect_y_hi_o, vid_data_o;
  logic [31:0] rect_y_lo_o, rect_x_hi_o, color_key_o, frame_period_o;
  logic [31:0] channel_timestamp_o;
  logic [15:0] color_key_len_o;
  logic [23:0] chan_id_i = 24'hA5C3E1;
  logic [15:0] invalid_type_o, tx_seq_o, rx_seq_o, codec_index_o;
  logic [11:0] target_view_index_o;
  logic [4:0]  bits_per_comp_o;
  logic [1:0]  comp_fmt_o, stereo_o;
  logic stream_closed_o, video_support_o, in_ready_o, rect_valid_o;
  logic sync_clk_o, cea_range_o, bt709_o, lines_even_o, color_valid_o;
  logic frame_last_flag_o, whole_display_o, codec_none_o, hdr_valid_o;
  logic present_hint_o, vid_end_o, vid_valid_o, vid_ready_i, frame_first_flag_o;
  logic frame_err_o, enc_err_o, seq_err_o, invalid_param_o;
  logic [32:0] vq[$];
  logic [12:0] cq[$];
  logic [31:0] ctl;
  int n_mismatch = 0, tests_run = 0, seed = 22, cyc = 0, n_full = 0;
  int n_fe = 0, n_se = 0, n_ip = 0, n_ee = 0, n_hint = 0, n_rect = 0;

  video_pdu_rx dut (.clk_i, .rst_i, .chan_id_i, .open_i, .close_resp_i,
    .stream_closed_o, .video_support_o, .in_data_i, .in_cmd_i, .in_last_i,
    .in_valid_i, .in_ready_o, .rect_x_lo_o, .rect_y_lo_o, .rect_x_hi_o,
    .rect_y_hi_o, .rect_valid_o, .color_key_o, .color_key_len_o,
    .frame_period_o, .pixel_format_byte_o(), .stereo_interlace_byte_o(),
    .sync_clk_o, .comp_fmt_o, .cea_range_o, .bt709_o, .bits_per_comp_o,
    .lines_even_o, .stereo_o, .color_valid_o, .channel_timestamp_o,
    .tx_seq_o, .rx_seq_o, .frame_last_flag_o, .frame_first_flag_o,
    .target_view_index_o, .whole_display_o, .codec_index_o, .codec_none_o,
    .hdr_valid_o, .present_hint_o, .vid_data_o, .vid_end_o, .vid_valid_o,
    .vid_ready_i, .frame_err_o, .enc_err_o, .seq_err_o, .invalid_param_o,
    .invalid_type_o);
  payload_sink sink (.clk_i(clk_i), .hold_i(hold), .vid_ready_o(vid_ready_i));

  always #10 clk_i = !clk_i;

  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Word stands until the edge at which ready is sampled high
  task automatic put(input logic [31:0] w, input logic c, input logic l);
    in_data_i  <= w;
    in_cmd_i   <= c;
    in_last_i  <= l;
    in_valid_i <= 1'b1;
    @(posedge clk_i);
    while (in_ready_o !== 1'b1) @(posedge clk_i);
  endtask

  task automatic unit(input logic [31:0] c, input int n, input logic q);
    logic [31:0] w;
    ctl = c;
    put({8'h00, chan_id_i}, 1'b1, 1'b0);
    put({8'h28, 8'h01, 16'(4 * (5 + n))}, 1'b1, 1'b0);
    put(32'h0BAD_F00D, 1'b1, 1'b0);
    put(32'hABCD_1357, 1'b1, 1'b0);
    put(c, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      w = $random(seed);
      if (q) vq.push_back({i == n - 1, w});
      put(w, 1'b1, i == n - 1);
    end
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
    if (!rst_i && in_ready_o === 1'b0) n_full++;
    n_fe += frame_err_o;
    n_se += seq_err_o;
    n_ee += enc_err_o;
    n_hint += present_hint_o;
    if (vid_valid_o && vid_ready_i)
      chk(vq.size() > 0 && {vid_end_o, vid_data_o} === vq.pop_front(), "data");
    if (hdr_valid_o) begin
      chk(tx_seq_o === 16'hABCD && rx_seq_o === 16'h1357
          && channel_timestamp_o === 32'h0BAD_F00D, "seq");
      chk({frame_last_flag_o, frame_first_flag_o, target_view_index_o,
          codec_index_o} === {ctl[31:30], ctl[27:16], ctl[15:0]},
          "ctl");
      chk(whole_display_o === (ctl[27:16] == 12'h000), "view");
      chk(codec_none_o === (ctl[15:0] == 16'h0000), "codec");
    end
    if (color_valid_o)
      chk(cq.size() > 0 && {sync_clk_o, comp_fmt_o, cea_range_o, bt709_o,
          bits_per_comp_o, lines_even_o, stereo_o} === cq.pop_front(), "col");
    if (rect_valid_o) begin
      n_rect++;
      chk(rect_x_lo_o === 32'hFFFF_FFF0 && rect_y_lo_o === 32'h1
          && rect_x_hi_o === 32'h40 && rect_y_hi_o === 32'h200, "rect");
    end
    if (invalid_param_o) begin
      n_ip++;
      chk(invalid_type_o === 16'h0009, "type");
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(video_support_o === 1'b1, "support");
    unit(32'h8000_0000, 3, 1'b1);
    fork
      begin repeat (60) @(posedge clk_i); hold <= 1'b0; end
    join_none
    hold <= 1'b1;
    unit(32'h0005_0002, 20, 1'b1);
    unit(32'h7000_0000, 1, 1'b1);
    put(32'h0004_0010, 1'b0, 1'b0);
    put(32'hFFFF_FFF0, 1'b0, 1'b0);
    put(32'h1, 1'b0, 1'b0);
    put(32'h40, 1'b0, 1'b0);
    put(32'h200, 1'b0, 1'b1);
    put(32'h0004_0008, 1'b0, 1'b0);
    put(32'h1, 1'b0, 1'b0);
    put(32'h2, 1'b0, 1'b1);
    put(32'h0009_0004, 1'b0, 1'b0);
    put(32'h0, 1'b0, 1'b1);
    put(32'h0005_0004, 1'b0, 1'b0);
    put(32'h00AB_CDEF, 1'b0, 1'b1);
    put(32'h0006_0004, 1'b0, 1'b0);
    put(32'h0000_411A, 1'b0, 1'b1);
    cq.push_back({1'b1, 2'h2, 1'b1, 1'b0, 5'h0C, 1'b1, 2'h3});
    put(32'h0003_0004, 1'b0, 1'b0);
    put(32'h6D07_0000, 1'b0, 1'b1);
    cq.push_back({1'b0, 2'h3, 1'b0, 1'b1, 5'h06, 1'b0, 2'h1});
    put(32'h0003_0004, 1'b0, 1'b0);
    put(32'h1602_0000, 1'b0, 1'b1);
    in_valid_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    close_resp_i <= 1'b1;
    @(posedge clk_i);
    close_resp_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(stream_closed_o === 1'b1, "closed");
    unit(32'h4000_0000, 2, 1'b0);
    in_valid_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    open_i <= 1'b1;
    @(posedge clk_i);
    open_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(stream_closed_o === 1'b0, "open");
    chk(vq.size() == 0 && cq.size() == 0 && n_full > 0, "drain");
    chk(n_fe == 1 && n_se == 1 && n_ee == 1, "errs");
    chk(n_hint == 1 && n_ip == 1 && n_rect == 1, "cnt");
    chk(color_key_o === 32'h00AB_CDEF && color_key_len_o === 16'h0004
        && frame_period_o === 32'h0000_411A, "key");
    report_and_stop();
  end
endmodule

`default_nettype wire
